/* src/shift_bank_map.vh */
// Address map, field layout and reset values of the indexed shift register bank
`ifndef SHIFT_BANK_MAP_VH
`define SHIFT_BANK_MAP_VH

// Bank geometry
`define SB_NUM_BANKS      4
`define SB_STAGES         8

// Register addresses (word addresses on the plain register port)
`define SB_CFG_HI         4'h0
`define SB_RETAIN_ADDR    8'h10
`define SB_BANK_HI        6'h08

// Per-instance configuration word fields
`define SB_CFG_IDX_LSB    0
`define SB_CFG_IDX_W      2
`define SB_CFG_BIT_LSB    2
`define SB_CFG_BIT_W      3
`define SB_CFG_W          5

// Reset values
`define SB_CFG_RST        5'h00
`define SB_RETAIN_RST     4'h0

`endif

/* src/rise_detect.v */
// Rising edge detector that compares each input with its value one cycle earlier
`timescale 1ns/10ps
module rise_detect #(
   parameter W = 4
) (
   // Clock and reset
   input  wire         clk_sys_i,
   input  wire         nrst_i,
   // Levels in, edges out
   input  wire [W-1:0] level_i,
   output wire [W-1:0] rise_o
);

   reg [W-1:0] prev;

   // A level already high when reset lifts counts as an edge in the first cycle
   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         prev <= {W{1'b0}};
      end else begin
         prev <= level_i;
      end
   end

   assign rise_o = level_i & ~prev;

endmodule // rise_detect

/* src/shift_bank.v */
// Bank of four 8-stage shift registers driven by indexed function instances
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "shift_bank_map.vh"

// Overview of operation
// - A shift happens only on a rising edge of an instance's trigger; falling edges do nothing.
// - With direction low the serial bit enters stage 1 and each stage moves up one, stage 8 lost.
// - With direction high the serial bit enters stage 8 and each stage moves down one, stage 1 lost.
// - A rising edge of the clear input zeroes all eight stages of the addressed bank and the output, unless a later instance on that bank shifts in the same cycle.
// - Outside reset the selected-bit output shows one stage, chosen by configuration from 1 to 8; reset holds it at zero.
// - There are four independent 8-stage banks, addressed by an index from 1 to 4.
// - Each instance works on the bank its index names, so instances with one index share storage.
// - A retentive bank keeps its stages over reset; a non-retentive one restarts cleared.
module shift_bank #(
   parameter NUM_FN = 4
) (
   // Clock and reset
   input  wire              clk_sys_i,
   input  wire              nrst_i,
   // Function instance inputs
   input  wire [NUM_FN-1:0] ser_in_i,
   input  wire [NUM_FN-1:0] trig_i,
   input  wire [NUM_FN-1:0] dir_i,
   input  wire [NUM_FN-1:0] clear_i,
   // Register port
   input  wire [7:0]        addr_i,
   input  wire [31:0]       wr_data_i,
   input  wire              wr_i,
   input  wire              rd_i,
   output reg  [31:0]       rd_data_o,
   // Function instance outputs
   output reg  [NUM_FN-1:0] sel_bit_o
);

   localparam BANK_W = `SB_NUM_BANKS * `SB_STAGES;

   reg  [`SB_CFG_W*NUM_FN-1:0] cfg;
   reg  [`SB_NUM_BANKS-1:0]    retain;
   reg  [BANK_W-1:0]           bank;
   reg  [BANK_W-1:0]           next_bank;
   reg  [NUM_FN-1:0]           next_sel;
   reg  [31:0]                 next_rd;
   wire [NUM_FN-1:0]           trg_rise;
   wire [NUM_FN-1:0]           clr_rise;
   wire                        cfg_wr;
   wire                        retain_wr;
   integer                     i;
   integer                     j;
   integer                     k;
   integer                     b;

   // Retention setting and retained stages live in storage that power loss
   // does not touch, so they start known without depending on reset.
   initial begin
      retain = `SB_RETAIN_RST;
      bank   = {BANK_W{1'b0}};
   end

   // Bank number (0..3) that instance n works on
   function integer cfg_bank;
      input [`SB_CFG_W*NUM_FN-1:0] c;
      input integer                n;
      begin
         cfg_bank = c[n*`SB_CFG_W+`SB_CFG_IDX_LSB +: `SB_CFG_IDX_W];
      end
   endfunction

   // Stage number (0..7) that instance n presents
   function integer cfg_stage;
      input [`SB_CFG_W*NUM_FN-1:0] c;
      input integer                n;
      begin
         cfg_stage = c[n*`SB_CFG_W+`SB_CFG_BIT_LSB +: `SB_CFG_BIT_W];
      end
   endfunction

   // Bit 0 holds stage 1, bit 7 stage 8
   function [7:0] shift_stage;
      input [7:0] s;
      input       din;
      input       dir;
      begin
         if (!dir) begin
            shift_stage = {s[6:0], din};
         end else begin
            shift_stage = {din, s[7:1]};
         end
      end
   endfunction

   // One bank's eight stages out of the flat storage vector
   function [7:0] bank_word;
      input [BANK_W-1:0] v;
      input integer      n;
      begin
         bank_word = v[n*`SB_STAGES +: `SB_STAGES];
      end
   endfunction

   // Configuration word of an instance; instances beyond NUM_FN are unmapped
   function cfg_hit;
      input [7:0] a;
      begin
         cfg_hit = (a[7:4] == `SB_CFG_HI) && (a[3:0] < NUM_FN);
      end
   endfunction

   function retain_hit;
      input [7:0] a;
      begin
         retain_hit = (a == `SB_RETAIN_ADDR);
      end
   endfunction

   // Stage status of one bank, read-only
   function bank_hit;
      input [7:0] a;
      begin
         bank_hit = (a[7:2] == `SB_BANK_HI);
      end
   endfunction

   rise_detect #(
      .W (NUM_FN)
   ) u_trg_edge (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .level_i   (trig_i),
      .rise_o    (trg_rise)
   );

   rise_detect #(
      .W (NUM_FN)
   ) u_clr_edge (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .level_i   (clear_i),
      .rise_o    (clr_rise)
   );

   // Write enables, decoded once for the register processes below
   assign cfg_wr    = wr_i && cfg_hit(addr_i);
   assign retain_wr = wr_i && retain_hit(addr_i);

   // Instances are evaluated in index order like a scan, so a later instance
   // on a shared bank sees the effect of an earlier one in the same cycle.
   always @* begin
      next_bank = bank;
      b         = 0;
      for (i = 0; i < NUM_FN; i = i + 1) begin
         b = cfg_bank(cfg, i);
         if (clr_rise[i]) begin
            next_bank[b*8 +: 8] = 8'h00;
         end else if (trg_rise[i]) begin
            next_bank[b*8 +: 8] = shift_stage(bank_word(next_bank, b),
                                              ser_in_i[i], dir_i[i]);
         end
      end
   end

   // Each output looks at its bank after this cycle's instances have acted
   always @* begin
      next_sel = {NUM_FN{1'b0}};
      for (j = 0; j < NUM_FN; j = j + 1) begin
         next_sel[j] = next_bank[cfg_bank(cfg, j)*8 + cfg_stage(cfg, j)];
      end
   end

   // Read decode; unmapped addresses answer zero
   always @* begin
      next_rd = 32'h0000_0000;
      if (rd_i) begin
         if (cfg_hit(addr_i)) begin
            next_rd[`SB_CFG_W-1:0] = cfg[addr_i[3:0]*`SB_CFG_W +: `SB_CFG_W];
         end else if (retain_hit(addr_i)) begin
            next_rd[`SB_NUM_BANKS-1:0] = retain;
         end else if (bank_hit(addr_i)) begin
            next_rd[7:0] = bank_word(bank, addr_i[1:0]);
         end
      end
   end

   // Retention mask survives reset on purpose, like the stages it protects
   always @(posedge clk_sys_i) begin
      if (retain_wr) begin
         retain <= wr_data_i[`SB_NUM_BANKS-1:0];
      end
   end

   // A retained bank simply skips the clear, so its stages ride through reset
   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         for (k = 0; k < `SB_NUM_BANKS; k = k + 1) begin
            if (!retain[k]) begin
               bank[k*8 +: 8] <= 8'h00;
            end
         end
      end else begin
         bank <= next_bank;
      end
   end

   // Instance configuration; every instance reverts to bank 1, stage 1
   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         cfg <= {NUM_FN{`SB_CFG_RST}};
      end else if (cfg_wr) begin
         cfg[addr_i[3:0]*`SB_CFG_W +: `SB_CFG_W] <= wr_data_i[`SB_CFG_W-1:0];
      end
   end

   // Read data stands for one cycle after the strobe, then falls back to zero
   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         rd_data_o <= 32'h0000_0000;
      end else begin
         rd_data_o <= next_rd;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         sel_bit_o <= {NUM_FN{1'b0}};
      end else begin
         sel_bit_o <= next_sel;
      end
   end

endmodule // shift_bank

/* bench/shift_bank_sva.sv */
// Port assertions for the shift bank
`timescale 1ns/10ps
module shift_bank_sva #(parameter NUM_FN = 4) (
   input wire              clk_sys_i, nrst_i, wr_i, rd_i,
   input wire [NUM_FN-1:0] ser_in_i, trig_i, dir_i, clear_i, sel_bit_o,
   input wire [7:0]        addr_i,
   input wire [31:0]       wr_data_i, rd_data_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   sequence s_wr_rd;
      wr_i && addr_i < NUM_FN ##1 rd_i && addr_i == $past(addr_i);
   endsequence
   property p_idle; !rd_i |=> rd_data_o == 0; endproperty
   property p_unmap; rd_i && addr_i >= 8'h24 |=> rd_data_o == 0; endproperty
   property p_bank; rd_i && addr_i[7:2] == 6'h08 |=> rd_data_o[31:8] == 0; endproperty
   property p_cfgw; rd_i && addr_i < NUM_FN |=> rd_data_o[31:5] == 0; endproperty
   property p_ret; rd_i && addr_i == 8'h10 |=> rd_data_o[31:4] == 0; endproperty
   property p_back; s_wr_rd |=> rd_data_o[4:0] == $past(wr_data_i[4:0], 2); endproperty
   // Another instance shifting into the same bank in that cycle could set the bit again
   property p_clr;
      $rose(clear_i[0]) && !wr_i && !(|(trig_i & ~$past(trig_i))) |=> !sel_bit_o[0];
   endproperty
   property p_hold;
      !wr_i && !$past(wr_i) && $past(nrst_i) && !(|(trig_i & ~$past(trig_i)))
         && !(|(clear_i & ~$past(clear_i))) |=> $stable(sel_bit_o);
   endproperty
   a_idle: assert property (p_idle) else $error("read data not zero when idle");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_bank: assert property (p_bank) else $error("bank read upper bits set");
   a_cfgw: assert property (p_cfgw) else $error("config read upper bits set");
   a_ret: assert property (p_ret) else $error("retain read upper bits set");
   a_back: assert property (p_back) else $error("config read back differs");
   a_clr: assert property (p_clr) else $error("output not zero after clear");
   a_hold: assert property (p_hold) else $error("output moved without an edge");
endmodule // shift_bank_sva
bind shift_bank shift_bank_sva #(.NUM_FN(NUM_FN)) chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
   .wr_i(wr_i), .rd_i(rd_i), .ser_in_i(ser_in_i), .trig_i(trig_i), .dir_i(dir_i),
   .clear_i(clear_i), .sel_bit_o(sel_bit_o), .addr_i(addr_i), .wr_data_i(wr_data_i),
   .rd_data_o(rd_data_o));

/* bench/upstream_blocks.sv */
// Upstream function blocks that present their levels once per scan cycle
`timescale 1ns/10ps
module upstream_blocks (
   input  wire logic       clk_sys_i,
   input  wire logic [3:0] want_ser_i, want_trig_i, want_dir_i, want_clr_i,
   output logic [3:0]      ser_o, trig_o, dir_o, clr_o
);
   // Levels change only at the scan edge, as from blocks evaluated earlier in the scan
   always @(posedge clk_sys_i)
      {ser_o, trig_o, dir_o, clr_o} <= {want_ser_i, want_trig_i, want_dir_i, want_clr_i};
endmodule // upstream_blocks

/* bench/tb_top.sv */
// Self-checking bench for the shift bank against a scan-cycle model
`timescale 1ns/10ps
module tb_top;
   logic        clk_sys_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
   logic [7:0]  addr_i = 8'h00, ra[5] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h0F};
   logic [31:0] wr_data_i = 32'h0, rd_data_o;
   logic [3:0]  ser, trig, dir, clr, sel_bit_o, pt, pc, es;
   logic [3:0]  w_ser = 0, w_trig = 0, w_dir = 0, w_clr = 0;
   int          n_fail = 0, cmp_count = 0, cfg[4], bk[4], ret = 0, rv, b;
   always #2 clk_sys_i = ~clk_sys_i;
   upstream_blocks up (.clk_sys_i, .want_ser_i(w_ser), .want_trig_i(w_trig),
      .want_dir_i(w_dir), .want_clr_i(w_clr), .ser_o(ser), .trig_o(trig), .dir_o(dir),
      .clr_o(clr));
   shift_bank #(.NUM_FN(4)) DUT (.clk_sys_i, .nrst_i, .ser_in_i(ser), .trig_i(trig),
      .dir_i(dir), .clear_i(clr), .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .sel_bit_o);
   task chk_rd(logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t rd_data_o got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_sel(logic [3:0] got, logic [3:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t sel_bit_o got %h exp %h", $time, got, exp);
      end
   endtask
   task bus(bit w, bit r, logic [7:0] a, logic [31:0] d);
      wr_i <= w; rd_i <= r; addr_i <= a; wr_data_i <= d;
      @(posedge clk_sys_i);
   endtask
   task run(int c);
      repeat (c) begin
         w_ser <= $urandom; w_trig <= $urandom; w_dir <= $urandom;
         w_clr <= $urandom & $urandom & $urandom;
         if ($urandom % 16 == 0) bus(1, 0, $urandom % 4, $urandom);
         else bus(0, 0, 0, 0);
      end
      {w_ser, w_trig, w_dir, w_clr} <= 0;
      repeat (3) bus(0, 0, 0, 0);
      for (int k = 0; k < 4; k++) bus(0, 1, 8'h20 + k, 0);
      bus(0, 0, 0, 0);
   endtask
   task complete_run;
      if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      // Read data answers the strobe of this edge and uses state from before it
      rv = 0;
      if (rd_i && nrst_i) rv = addr_i[7:2] == 6'h08 ? bk[addr_i[1:0]] : addr_i == 8'h10 ? ret :
                               addr_i < 4 ? cfg[addr_i] : 0;
      if (!nrst_i) begin
         pt = 0; pc = 0; es = 0;
         for (int n = 0; n < 4; n++) begin
            cfg[n] = 0;
            if (!ret[n]) bk[n] = 0;
         end
      end else begin
         for (int n = 0; n < 4; n++) begin
            b = cfg[n] & 3;
            if (clr[n] && !pc[n]) bk[b] = 0;
            else if (trig[n] && !pt[n]) bk[b] = dir[n] ? bk[b] >> 1 | ser[n] << 7 :
                                             (bk[b] << 1 | ser[n]) & 255;
         end
         // Outputs still follow the configuration that stood before this edge
         for (int n = 0; n < 4; n++) es[n] = bk[cfg[n] & 3] >> (cfg[n] >> 2) & 1;
         pt = trig; pc = clr;
         if (wr_i && addr_i < 4) cfg[addr_i] = wr_data_i[4:0];
      end
      if (wr_i && addr_i == 8'h10) ret = wr_data_i[3:0];
      #1;
      chk_rd(rd_data_o, rv);
      chk_sel(sel_bit_o, es);
   end
   initial begin
      #40000;
      n_fail++;
      complete_run();
   end
   initial begin
      void'($urandom(32'h6e90));
      repeat (5) @(posedge clk_sys_i);
      nrst_i <= 1;
      foreach (ra[k]) bus(0, 1, ra[k], 0);
      // Instances 0 and 1 share bank 1 so their shifts interleave in one storage
      for (int i = 0; i < 4; i++) begin
         bus(1, 0, i, ($urandom % 8) << 2 | (i < 2 ? 0 : i));
         bus(0, 1, i, 0);
      end
      run(800);
      bus(1, 0, 8'h10, 5);
      bus(0, 1, 8'h10, 0);
      nrst_i <= 0;
      repeat (2) bus(0, 0, 0, 0);
      nrst_i <= 1;
      for (int k = 0; k < 4; k++) bus(0, 1, 8'h20 + k, 0);
      run(300);
      complete_run();
   end
endmodule // tb_top
